// [include/lasgc_pkg.sv]
// Package of constants for the link address strap and general-purpose pin block.
// Assumes a 100 MHz core clock and an 8-bit register port.
package lasgc_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int FWD_SKEW_MAX_NS  = 25000;
   localparam int FWD_PERIOD_NS    = 5000;
   localparam int FWD_CYCLES       = FWD_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES    = 4;

   // ---------------------------------------------------------------
   // Address decoding
   // ---------------------------------------------------------------
   localparam logic [6:0] SER_ADDR_BASE  = 7'h58;
   localparam logic [6:0] SER_ADDR_LAST  = 7'h5d;
   localparam logic [2:0] SER_LEVEL_MAX  = 3'h5;
   localparam logic [6:0] DES_ADDR_BASE  = 7'h60;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_SER_GPO    = 8'h00;
   localparam logic [7:0] OFS_DES_GPIO   = 8'h01;
   localparam logic [7:0] OFS_SPREAD     = 8'h02;
   localparam logic [7:0] OFS_EQ         = 8'h03;
   localparam logic [7:0] OFS_SER_ADDR   = 8'h04;
   localparam logic [7:0] OFS_DES_ADDR   = 8'h05;
   localparam logic [7:0] OFS_SER_WADDR  = 8'h06;
   localparam logic [7:0] OFS_DES_WADDR  = 8'h07;
   localparam logic [7:0] OFS_STATUS     = 8'h08;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SEL_LSB   = 0;
   localparam int VAL_LSB   = 4;
   localparam int EQ_MAN_B  = 4;
   localparam int ST_MODE_B = 7;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_SER_GPO  = 8'h00;
   localparam logic [7:0] RST_DES_GPIO = 8'h00;
   localparam logic [3:0] RST_SPREAD   = 4'h0;
   localparam logic [4:0] RST_EQ       = 5'h00;

   // ---------------------------------------------------------------
   // Strap capture states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CAP_SETTLE = 2'b00,
      CAP_HOLD   = 2'b01
   } lasgc_cap_t;

endpackage

// [core/lasgc_top.sv]
// Strap address decode, register port and general-purpose pin routing of a link chipset.
// Assumes straps, pins and oscillator are asynchronous and a master on the register port.
//
// Behaviour
// - The serializer strap level selects one address from 0x58 to 0x5d.
// - The write form of an address is the address shifted left with a zero below.
// - Two four-level deserializer straps give 0x60 plus high level times four plus low level.
// - A register port writes and reads the configuration and controls the pins.
// - With the pixel clock reference there are four serializer outputs and four deserializer pins.
// - With the pixel clock reference each serializer output drives either the forwarded deserializer pin or a local bit.
// - Each deserializer pin is an input forwarded across or an output of a local bit.
// - In oscillator mode serializer output three becomes the oscillator input.
// - In oscillator mode deserializer pins two and three drive only local bits.
// - In oscillator mode the oscillator divided by two goes to the imager.
// - Forwarding serves toggle rates up to 66 kHz and the far side stays below it.
// - Forwarded edges are sampled often enough to keep link skew within 25 us.
// - Register 0x02 bits 3 to 0 select the spread spectrum profile.
// - The equalizer adapts by default and may be set to a manual level.
// - A mode strap selects oscillator or pixel clock reference and so the pin roles.
`timescale 1ns/1ps
`default_nettype none

module lasgc_top
   import lasgc_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic       ce_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic [2:0] ser_address_strap_in,
   input  wire logic [1:0] des_address_strap_low_in,
   input  wire logic [1:0] des_address_strap_high_in,
   input  wire logic       ref_osc_mode_strap_in,
   input  wire logic       ser_output_three_in,
   output logic      [3:0] ser_gpo_out,
   output logic      [3:0] ser_gpo_oe_n_out,
   input  wire logic [3:0] des_gpio_in,
   output logic      [3:0] des_gpio_out,
   output logic      [3:0] des_gpio_oe_n_out,
   output logic      [6:0] ser_slave_addr_out,
   output logic      [6:0] des_slave_addr_out,
   output logic            osc_mode_out,
   output logic      [3:0] spread_spectrum_clocking_out,
   output logic            adaptive_receive_equalizer_out,
   output logic      [3:0] eq_manual_level_out
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] write_form(input logic [6:0] addr);
      write_form = {addr, 1'b0};
   endfunction

   function automatic logic write_hit(input logic       wr,
                                      input logic [7:0] addr,
                                      input logic [7:0] ofs);
      write_hit = wr && (addr == ofs);
   endfunction

   localparam logic [9:0] FWD_LAST    = 10'(FWD_CYCLES - 1);
   localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYCLES - 1);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [7:0] strap_s1_ff;
   logic [7:0] strap_s2_ff;
   logic [3:0] pin_s1_ff;
   logic [3:0] pin_s2_ff;
   logic       osc_s1_ff;
   logic       osc_s2_ff;
   logic       osc_s3_ff;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         strap_s1_ff <= 8'h00;
         strap_s2_ff <= 8'h00;
      end else if (ce_in) begin
         strap_s1_ff <= {ref_osc_mode_strap_in, des_address_strap_high_in,
                         des_address_strap_low_in, ser_address_strap_in};
         strap_s2_ff <= strap_s1_ff;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
      end else if (ce_in) begin
         pin_s1_ff <= des_gpio_in;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // A third stage keeps the previous oscillator level for edge detection.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_s3_ff <= 1'b0;
      end else if (ce_in) begin
         osc_s1_ff <= ser_output_three_in;
         osc_s2_ff <= osc_s1_ff;
         osc_s3_ff <= osc_s2_ff;
      end
   end

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------
   lasgc_cap_t cap_state_ff;
   lasgc_cap_t nxt_cap_state;
   logic [2:0] settle_cnt_ff;
   logic [6:0] ser_addr_ff;
   logic [6:0] des_addr_ff;
   logic       osc_mode_ff;
   logic [6:0] ser_addr_dec;
   logic [6:0] des_addr_dec;
   logic       cap_take;

   always_comb begin
      if (strap_s2_ff[2:0] > SER_LEVEL_MAX) begin
         ser_addr_dec = SER_ADDR_LAST;
      end else begin
         ser_addr_dec = SER_ADDR_BASE + {4'h0, strap_s2_ff[2:0]};
      end
      des_addr_dec = DES_ADDR_BASE + {3'h0, strap_s2_ff[6:5], strap_s2_ff[4:3]};
   end

   always_comb begin
      case (cap_state_ff)
         CAP_SETTLE: begin
            if (settle_cnt_ff == SETTLE_LAST) begin
               nxt_cap_state = CAP_HOLD;
            end else begin
               nxt_cap_state = CAP_SETTLE;
            end
         end
         CAP_HOLD: nxt_cap_state = CAP_HOLD;
         default:  nxt_cap_state = CAP_SETTLE;
      endcase
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cap_state_ff  <= CAP_SETTLE;
         settle_cnt_ff <= 3'h0;
      end else if (ce_in) begin
         cap_state_ff <= nxt_cap_state;
         if (cap_state_ff == CAP_SETTLE) begin
            settle_cnt_ff <= settle_cnt_ff + 3'h1;
         end
      end
   end

   assign cap_take = ce_in && (cap_state_ff == CAP_SETTLE) && (settle_cnt_ff == SETTLE_LAST);

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         ser_addr_ff <= SER_ADDR_BASE;
         des_addr_ff <= DES_ADDR_BASE;
      end else if (cap_take) begin
         ser_addr_ff <= ser_addr_dec;
         des_addr_ff <= des_addr_dec;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         osc_mode_ff <= 1'b0;
      end else if (cap_take) begin
         osc_mode_ff <= strap_s2_ff[7];
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [7:0] ser_gpo_ff;
   logic [7:0] des_gpio_ff;
   logic [3:0] spread_ff;
   logic [4:0] eq_ff;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         ser_gpo_ff <= RST_SER_GPO;
      end else if (ce_in && write_hit(reg_wr_in, reg_addr_in, OFS_SER_GPO)) begin
         ser_gpo_ff <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         des_gpio_ff <= RST_DES_GPIO;
      end else if (ce_in && write_hit(reg_wr_in, reg_addr_in, OFS_DES_GPIO)) begin
         des_gpio_ff <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         spread_ff <= RST_SPREAD;
      end else if (ce_in && write_hit(reg_wr_in, reg_addr_in, OFS_SPREAD)) begin
         spread_ff <= reg_wdata_in[3:0];
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         eq_ff <= RST_EQ;
      end else if (ce_in && write_hit(reg_wr_in, reg_addr_in, OFS_EQ)) begin
         eq_ff <= reg_wdata_in[4:0];
      end
   end

   // ---------------------------------------------------------------
   // Deserializer pin direction and forwarding
   // ---------------------------------------------------------------
   logic [3:0] des_drive;
   logic [9:0] fwd_cnt_ff;
   logic [3:0] fwd_ff;

   always_comb begin
      des_drive = des_gpio_ff[SEL_LSB +: 4];
      if (osc_mode_ff) begin
         des_drive[3:2] = 2'b11;
      end
   end

   // Sampling every few microseconds bounds the forwarded edge skew between links.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         fwd_cnt_ff <= 10'h000;
         fwd_ff     <= 4'h0;
      end else if (ce_in) begin
         if (fwd_cnt_ff == FWD_LAST) begin
            fwd_cnt_ff <= 10'h000;
            fwd_ff     <= pin_s2_ff & ~des_drive;
         end else begin
            fwd_cnt_ff <= fwd_cnt_ff + 10'h001;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         des_gpio_out      <= 4'h0;
         des_gpio_oe_n_out <= 4'hf;
      end else if (ce_in) begin
         des_gpio_out      <= des_gpio_ff[VAL_LSB +: 4] & des_drive;
         des_gpio_oe_n_out <= ~des_drive;
      end
   end

   // ---------------------------------------------------------------
   // Serializer outputs and oscillator divider
   // ---------------------------------------------------------------
   logic       div_ff;
   logic [3:0] ser_mux;
   logic       osc_rise;

   // Only a rising oscillator edge toggles the divider, which halves the frequency.
   assign osc_rise = osc_s2_ff && !osc_s3_ff;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         div_ff <= 1'b0;
      end else if (ce_in) begin
         if (!osc_mode_ff) begin
            div_ff <= 1'b0;
         end else if (osc_rise) begin
            div_ff <= ~div_ff;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (ser_gpo_ff[SEL_LSB + i]) begin
            ser_mux[i] = ser_gpo_ff[VAL_LSB + i];
         end else begin
            ser_mux[i] = fwd_ff[i];
         end
      end
      if (osc_mode_ff) begin
         ser_mux[2] = div_ff;
         ser_mux[3] = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         ser_gpo_out      <= 4'h0;
         ser_gpo_oe_n_out <= 4'h0;
      end else if (ce_in) begin
         ser_gpo_out      <= ser_mux;
         ser_gpo_oe_n_out <= {osc_mode_ff, 3'b000};
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   logic [7:0] nxt_rdata;

   always_comb begin
      case (reg_addr_in)
         OFS_SER_GPO:   nxt_rdata = ser_gpo_ff;
         OFS_DES_GPIO:  nxt_rdata = des_gpio_ff;
         OFS_SPREAD:    nxt_rdata = {4'h0, spread_ff};
         OFS_EQ:        nxt_rdata = {3'h0, eq_ff};
         OFS_SER_ADDR:  nxt_rdata = {1'b0, ser_addr_ff};
         OFS_DES_ADDR:  nxt_rdata = {1'b0, des_addr_ff};
         OFS_SER_WADDR: nxt_rdata = write_form(ser_addr_ff);
         OFS_DES_WADDR: nxt_rdata = write_form(des_addr_ff);
         OFS_STATUS:    nxt_rdata = {osc_mode_ff, 3'h0, pin_s2_ff};
         default:       nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else if (ce_in) begin
         if (reg_rd_in) begin
            reg_rdata_out <= nxt_rdata;
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status outputs
   // ---------------------------------------------------------------
   assign ser_slave_addr_out             = ser_addr_ff;
   assign des_slave_addr_out             = des_addr_ff;
   assign osc_mode_out                   = osc_mode_ff;
   assign spread_spectrum_clocking_out   = spread_ff;
   assign adaptive_receive_equalizer_out = ~eq_ff[EQ_MAN_B];
   assign eq_manual_level_out            = eq_ff[3:0];

endmodule // lasgc_top

`default_nettype wire

// [testbench/lasgc_checker.sv]
// Checker of the strap address, register port and pin routing ports.
// Assumes a bind to lasgc_top and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lasgc_checker
   import lasgc_pkg::*;
(
   input wire logic       mclk_in,
   input wire logic       reset_in,
   input wire logic       ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [3:0] ser_gpo_oe_n_out,
   input wire logic [3:0] des_gpio_out,
   input wire logic [3:0] des_gpio_oe_n_out,
   input wire logic [6:0] ser_slave_addr_out,
   input wire logic [6:0] des_slave_addr_out,
   input wire logic       osc_mode_out,
   input wire logic [3:0] spread_spectrum_clocking_out,
   input wire logic       adaptive_receive_equalizer_out
);
   logic [3:0] run_ff;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   // Counts enabled edges since reset, saturating.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) run_ff <= 4'h0;
      else if (ce_in && run_ff != 4'hf) run_ff <= run_ff + 4'h1;
   end
   a_read_idle_zero: assert property ($past(ce_in) && !$past(reg_rd_in) |->
      reg_rdata_out == 8'h00) else $error("read data outside answer cycle");
   a_ser_addr_range: assert property (ser_slave_addr_out >= SER_ADDR_BASE &&
      ser_slave_addr_out <= SER_ADDR_LAST) else $error("serializer address out of range");
   a_des_addr_base: assert property (des_slave_addr_out[6:4] == 3'h6)
      else $error("deserializer address out of range");
   a_addr_held: assert property (run_ff == 4'hf |-> $stable(ser_slave_addr_out) &&
      $stable(des_slave_addr_out)) else $error("address changed after capture");
   a_osc_three_in: assert property (osc_mode_out && $past(osc_mode_out, 2) |->
      ser_gpo_oe_n_out[3]) else $error("output three driven in oscillator mode");
   a_osc_local_pins: assert property (osc_mode_out && $past(osc_mode_out, 2) |->
      des_gpio_oe_n_out[3:2] == 2'b00) else $error("pins two three not outputs");
   a_osc_div_drive: assert property (osc_mode_out && $past(osc_mode_out, 2) |->
      !ser_gpo_oe_n_out[2]) else $error("divided clock output not driven");
   a_pixel_all_out: assert property (!osc_mode_out && !$past(osc_mode_out, 2) |->
      ser_gpo_oe_n_out == 4'h0) else $error("serializer outputs not driven");
   a_input_no_drive: assert property ((des_gpio_out & des_gpio_oe_n_out) == 4'h0)
      else $error("input pin shows a drive value");
   a_spread_write: assert property (reg_wr_in && ce_in && reg_addr_in == OFS_SPREAD |=>
      spread_spectrum_clocking_out == 4'($past(reg_wdata_in))) else $error("spread not written");
   a_eq_mode_write: assert property (reg_wr_in && ce_in && reg_addr_in == OFS_EQ |=>
      adaptive_receive_equalizer_out != 1'($past(reg_wdata_in) >> EQ_MAN_B))
      else $error("equalizer mode not written");
   a_reset_defaults: assert property (disable iff (1'b0) reset_in |->
      adaptive_receive_equalizer_out && reg_rdata_out == 8'h00) else $error("reset values wrong");
   c_spread_write: cover property (reg_wr_in && ce_in && reg_addr_in == OFS_SPREAD);
   c_osc_mode: cover property (osc_mode_out && $past(osc_mode_out, 2));
   c_status_read: cover property (reg_rd_in && ce_in && reg_addr_in == OFS_STATUS);
endmodule // lasgc_checker
`default_nettype wire

// [testbench/lasgc_far_model.sv]
// Far-side model: remote pin driver and external oscillator.
// Assumes the bench requests pin levels and sees the design's pin enables.
`timescale 1ns/1ps
`default_nettype none
module lasgc_far_model #(
   parameter int MIN_GAP = 1516
) (
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic [3:0] pin_req_in,
   input  wire logic [3:0] des_drive_in,
   input  wire logic [3:0] des_oe_n_in,
   output logic      [3:0] pin_level_out,
   output logic            osc_out
);
   logic [3:0]  held_ff;
   logic [10:0] gap_ff;
   logic [2:0]  div_ff;
   // Pin changes are spaced to stay under the forwarding toggle rate.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         held_ff <= 4'h0;
         gap_ff  <= 11'(MIN_GAP);
      end else if (pin_req_in != held_ff && gap_ff >= 11'(MIN_GAP)) begin
         held_ff <= pin_req_in;
         gap_ff  <= 11'h000;
      end else if (gap_ff < 11'(MIN_GAP)) begin
         gap_ff <= gap_ff + 11'h001;
      end
   end
   // Oscillator at one eighth of the core clock.
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) div_ff <= 3'h0;
      else div_ff <= div_ff + 3'h1;
   end
   assign osc_out = div_ff[2];
   assign pin_level_out = (des_oe_n_in & held_ff) | (~des_oe_n_in & des_drive_in);
endmodule // lasgc_far_model
`default_nettype wire

// [testbench/tb_top.sv]
// Bench of the strap address, register port and pin routing block.
// Assumes lasgc_top, lasgc_far_model and lasgc_checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import lasgc_pkg::*;
   logic       mclk_in = 1'b0, reset_in = 1'b0, ce_in = 1'b1, reg_wr_in = 1'b0;
   logic       reg_rd_in = 1'b0, mode = 1'b0, osc, g;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic [2:0] ser_lvl = 3'h3;
   logic [1:0] des_lo = 2'h2, des_hi = 2'h1;
   logic [3:0] pin_req = 4'h0, pins, ser_gpo_out, ser_gpo_oe_n_out, des_gpio_out;
   logic [3:0] des_gpio_oe_n_out, spread_spectrum_clocking_out, eq_manual_level_out;
   logic [6:0] ser_slave_addr_out, des_slave_addr_out;
   logic       osc_mode_out, adaptive_receive_equalizer_out;
   int         errors = 0, cmp_count = 0, cycles = 0, n;
   always #5 mclk_in = ~mclk_in;
   lasgc_top lasgc_top_i (.mclk_in, .reset_in, .ce_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ser_address_strap_in(ser_lvl),
      .des_address_strap_low_in(des_lo), .des_address_strap_high_in(des_hi),
      .ref_osc_mode_strap_in(mode), .ser_output_three_in(osc), .ser_gpo_out,
      .ser_gpo_oe_n_out, .des_gpio_in(pins), .des_gpio_out, .des_gpio_oe_n_out,
      .ser_slave_addr_out, .des_slave_addr_out, .osc_mode_out, .spread_spectrum_clocking_out,
      .adaptive_receive_equalizer_out, .eq_manual_level_out);
   lasgc_far_model lasgc_far_model_i (.mclk_in, .reset_in, .pin_req_in(pin_req),
      .des_drive_in(des_gpio_out), .des_oe_n_in(des_gpio_oe_n_out), .pin_level_out(pins),
      .osc_out(osc));
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, exp);
   endtask
   task automatic boot(input logic [2:0] l, input logic [1:0] lo, input logic [1:0] hi,
                       input logic m);
      @(posedge mclk_in);
      reset_in <= 1'b1;
      ser_lvl  <= l;
      des_lo   <= lo;
      des_hi   <= hi;
      mode     <= m;
      repeat (5) @(posedge mclk_in);
      reset_in <= 1'b0;
      repeat (8) @(posedge mclk_in);
      #1;
   endtask
   task automatic wait_gpo(input logic [3:0] exp);
      n = 0;
      while (ser_gpo_out !== exp && n < 2200) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      #1 chk({4'h0, ser_gpo_out}, {4'h0, exp});
   endtask
   initial begin
      reset_in <= 1'b1;
      boot(3'h3, 2'h2, 2'h1, 1'b0);
      chk({1'b0, ser_slave_addr_out}, 8'h5b);
      rd(OFS_SER_WADDR, 8'hb6);
      rd(OFS_DES_ADDR, 8'h66);
      rd(OFS_DES_WADDR, 8'hcc);
      wr(OFS_SER_ADDR, 8'hff);
      rd(OFS_SER_ADDR, 8'h5b);
      rd(8'h3f, 8'h00);
      chk({7'h0, adaptive_receive_equalizer_out}, 8'h01);
      wr(OFS_EQ, 8'h15);
      rd(OFS_EQ, 8'h15);
      chk({3'h0, !adaptive_receive_equalizer_out, eq_manual_level_out}, 8'h15);
      wr(OFS_SPREAD, 8'h0a);
      @(posedge mclk_in);
      ce_in <= 1'b0;
      wr(OFS_SPREAD, 8'h07);
      ce_in <= 1'b1;
      rd(OFS_SPREAD, 8'h0a);
      chk({4'h0, spread_spectrum_clocking_out}, 8'h0a);
      wr(OFS_DES_GPIO, 8'h00);
      wr(OFS_SER_GPO, 8'h00);
      pin_req <= 4'h5;
      wait_gpo(4'h5);
      chk((n <= 506) ? 8'h01 : 8'h00, 8'h01);
      rd(OFS_STATUS, 8'h05);
      pin_req <= 4'ha;
      wait_gpo(4'ha);
      wr(OFS_SER_GPO, 8'h9f);
      wr(OFS_DES_GPIO, 8'hcc);
      repeat (2) @(posedge mclk_in);
      #1 chk({ser_gpo_out, des_gpio_out}, 8'h9c);
      chk({4'h0, des_gpio_oe_n_out}, 8'h03);
      rd(OFS_STATUS, 8'h0e);
      rd(OFS_SER_GPO, 8'h9f);
      rd(OFS_DES_GPIO, 8'hcc);
      boot(3'h7, 2'h3, 2'h3, 1'b0);
      @(posedge mclk_in);
      ser_lvl <= 3'h0;
      des_hi  <= 2'h0;
      repeat (4) @(posedge mclk_in);
      #1 chk({1'b0, ser_slave_addr_out}, 8'h5d);
      chk({1'b0, des_slave_addr_out}, 8'h6f);
      for (int l = 0; l < 6; l++) begin
         boot(3'(l), 2'(l), 2'(3 - l), l == 5);
         chk({1'b0, ser_slave_addr_out}, 8'h58 + 8'(l));
         rd(OFS_SER_WADDR, 8'hb0 + 8'(2 * l));
         chk({1'b0, des_slave_addr_out}, 8'h60 + 8'(((3 - l) & 3) * 4 + (l & 3)));
      end
      rd(OFS_STATUS, 8'h82);
      chk({4'h0, ser_gpo_oe_n_out}, 8'h08);
      chk({4'h0, des_gpio_oe_n_out}, 8'h03);
      n = 0;
      g = ser_gpo_out[2];
      for (int i = 0; i < 800; i++) begin
         @(posedge mclk_in);
         #1;
         if (ser_gpo_out[2] !== g) n++;
         g = ser_gpo_out[2];
      end
      chk((n >= 99 && n <= 101) ? 8'h01 : 8'h00, 8'h01);
      end_sim();
   end
endmodule // tb_top
bind lasgc_top lasgc_checker lasgc_checker_i (.mclk_in, .reset_in, .ce_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ser_gpo_oe_n_out, .des_gpio_out,
   .des_gpio_oe_n_out, .ser_slave_addr_out, .des_slave_addr_out, .osc_mode_out,
   .spread_spectrum_clocking_out, .adaptive_receive_equalizer_out);
`default_nettype wire
